// ---- common/tlbm_pkg.sv ----
// Purpose: Constants for the TLB management block.
// Assumes: 32-bit mode register layouts only.
// Notes:   Register index is the coprocessor register number.
package tlbm_pkg;
  localparam int          TLBM_ENTRIES    = 32;
  localparam int          TLBM_IDX_W      = 5;
  localparam logic [4:0]  TLBM_IDX_TOP    = 5'h1F;
  localparam logic [4:0]  TLBM_IDX_ZERO   = 5'h00;
  // Register addresses (register numbers).
  localparam logic [4:0]  TLBM_A_SEL      = 5'h00;
  localparam logic [4:0]  TLBM_A_RAND     = 5'h01;
  localparam logic [4:0]  TLBM_A_LO0      = 5'h02;
  localparam logic [4:0]  TLBM_A_LO1      = 5'h03;
  localparam logic [4:0]  TLBM_A_MASK     = 5'h05;
  localparam logic [4:0]  TLBM_A_WIRED    = 5'h06;
  localparam logic [4:0]  TLBM_A_HI       = 5'h0A;
  localparam logic [4:0]  TLBM_A_IRQ_ST   = 5'h18;
  localparam logic [4:0]  TLBM_A_IRQ_MSK  = 5'h19;
  // Field layouts.
  localparam int          TLBM_PROBE_BIT  = 31;
  localparam logic [31:0] TLBM_LO_MASK    = 32'h3FFFFFFF;
  localparam logic [31:0] TLBM_HI_MASK    = 32'hFFFFE0FF;
  localparam logic [31:0] TLBM_PM_MASK    = 32'h0007F800;
  localparam logic [31:0] TLBM_SEL_MASK   = 32'h8000001F;
  localparam logic [2:0]  TLBM_C_UNCACHED = 3'h2;
  localparam int          TLBM_D_BIT      = 2;
  localparam int          TLBM_V_BIT      = 1;
  localparam int          TLBM_G_BIT      = 0;
  // Interrupt status bits.
  localparam int          TLBM_EV_MISS    = 0;
  localparam int          TLBM_EV_INV     = 1;
  localparam int          TLBM_EV_MOD     = 2;
  localparam int          TLBM_EV_W       = 3;
  localparam logic [2:0]  TLBM_EV_NONE    = 3'h0;
  // Instruction codes.
  typedef enum logic [2:0] {
    TLBM_OP_NONE  = 3'b000,
    TLBM_OP_PROBE = 3'b001,
    TLBM_OP_READ  = 3'b010,
    TLBM_OP_WRIDX = 3'b011,
    TLBM_OP_WRRND = 3'b100
  } tlbm_op_t;
endpackage

// ---- core/tlbm_core.sv ----
// Purpose: 32-entry TLB with its management registers and lookup port.
// Assumes: One instruction per op strobe; lookup results are registered one cycle later.
// Notes:   Events from lookups raise a maskable level interrupt.
`timescale 1ns/100ps
module tlbm_core
  import tlbm_pkg::*;
#(
  parameter int N_ENT = TLBM_ENTRIES
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [2:0]  op_code,
  input  wire logic        op_valid,
  input  wire logic        instr_retire,
  input  wire logic        lk_valid,
  input  wire logic [31:0] lk_vaddr,
  input  wire logic        lk_store,
  output logic             lk_hit,
  output logic      [31:0] lk_paddr,
  output logic             lk_uncached,
  output logic             lk_exc_miss,
  output logic             lk_exc_load_inv,
  output logic             lk_exc_store_inv,
  output logic             lk_exc_mod,
  output logic             irq
);
  // Entry storage, one slot per TLB entry.
  logic [31:0] ent_hi_ff   [N_ENT];
  logic [31:0] ent_mask_ff [N_ENT];
  logic [29:0] ent_lo0_ff  [N_ENT];
  logic [29:0] ent_lo1_ff  [N_ENT];
  logic        ent_g_ff    [N_ENT];

  logic [31:0] sel_ff;
  logic [4:0]  rand_ff;
  logic [4:0]  wired_ff;
  logic [31:0] lo0_ff;
  logic [31:0] lo1_ff;
  logic [31:0] mask_ff;
  logic [31:0] hi_ff;
  logic [TLBM_EV_W-1:0] ist_ff;
  logic [TLBM_EV_W-1:0] imsk_ff;
  logic [31:0] nxt_rdata;

  tlbm_op_t op;
  assign op = tlbm_op_t'(op_code);

  logic        do_probe;
  logic        do_read;
  logic        do_wridx;
  logic        do_wrrnd;
  logic        do_write;
  logic [4:0]  wr_idx;
  assign do_probe = op_valid && (op == TLBM_OP_PROBE);
  assign do_read  = op_valid && (op == TLBM_OP_READ);
  assign do_wridx = op_valid && (op == TLBM_OP_WRIDX);
  assign do_wrrnd = op_valid && (op == TLBM_OP_WRRND);
  assign do_write = do_wridx || do_wrrnd;
  // Indexed writes use the selector, random writes the replacement index.
  assign wr_idx = do_wrrnd ? rand_ff : sel_ff[4:0];

  // Match each entry against a virtual page and an address space id.
  logic [N_ENT-1:0] probe_hit;
  logic [N_ENT-1:0] look_hit;
  genvar gi;
  generate
    for (gi = 0; gi < N_ENT; gi++) begin : g_match
      logic [31:0] cmp_msk;
      logic        address_space_identifier_ok_p;
      logic        address_space_identifier_ok_l;
      assign cmp_msk = ~(ent_mask_ff[gi] | 32'h00001FFF);
      // A global entry ignores the address space id.
      assign address_space_identifier_ok_p = ent_g_ff[gi] ||
                         (ent_hi_ff[gi][7:0] == hi_ff[7:0]);
      assign address_space_identifier_ok_l = ent_g_ff[gi] ||
                         (ent_hi_ff[gi][7:0] == hi_ff[7:0]);
      assign probe_hit[gi] = address_space_identifier_ok_p &&
        (((ent_hi_ff[gi] ^ hi_ff) & cmp_msk) == 32'h00000000);
      assign look_hit[gi] = lk_valid && address_space_identifier_ok_l &&
        (((ent_hi_ff[gi] ^ lk_vaddr) & cmp_msk) == 32'h00000000);
    end
  endgenerate

  // Encode the lowest matching entry.
  logic [4:0] probe_idx;
  logic [4:0] look_idx;
  always_comb begin
    probe_idx = TLBM_IDX_ZERO;
    look_idx  = TLBM_IDX_ZERO;
    for (int i = N_ENT - 1; i >= 0; i--) begin
      if (probe_hit[i]) begin
        probe_idx = i[4:0];
      end
      if (look_hit[i]) begin
        look_idx = i[4:0];
      end
    end
  end

  // Entry selector: software index plus probe outcome flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_ff <= 32'h00000000;
    end else if (do_probe) begin
      if (|probe_hit) begin
        sel_ff <= {27'h0000000, probe_idx};
      end else begin
        sel_ff <= 32'h80000000 | (sel_ff & 32'h0000001F);
      end
    end else if (reg_wr && reg_addr == TLBM_A_SEL) begin
      sel_ff <= reg_wdata & TLBM_SEL_MASK;
    end
  end

  // Replacement index walks down from 31 to the locked boundary.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rand_ff <= TLBM_IDX_TOP;
    end else if (reg_wr && reg_addr == TLBM_A_WIRED) begin
      rand_ff <= TLBM_IDX_TOP;
    end else if (instr_retire) begin
      if (rand_ff <= wired_ff) begin
        rand_ff <= TLBM_IDX_TOP;
      end else begin
        rand_ff <= rand_ff - 5'h01;
      end
    end
  end

  // Locked-entry boundary.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wired_ff <= TLBM_IDX_ZERO;
    end else if (reg_wr && reg_addr == TLBM_A_WIRED) begin
      wired_ff <= reg_wdata[4:0];
    end
  end

  // Staging registers load from software or from an indexed read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo0_ff  <= 32'h00000000;
      lo1_ff  <= 32'h00000000;
      mask_ff <= 32'h00000000;
      hi_ff   <= 32'h00000000;
    end else if (do_read) begin
      lo0_ff  <= {2'h0, ent_lo0_ff[sel_ff[4:0]][29:1],
                  ent_g_ff[sel_ff[4:0]]};
      lo1_ff  <= {2'h0, ent_lo1_ff[sel_ff[4:0]][29:1],
                  ent_g_ff[sel_ff[4:0]]};
      mask_ff <= ent_mask_ff[sel_ff[4:0]];
      hi_ff   <= ent_hi_ff[sel_ff[4:0]];
    end else if (reg_wr) begin
      case (reg_addr)
        TLBM_A_LO0:  lo0_ff  <= reg_wdata & TLBM_LO_MASK;
        TLBM_A_LO1:  lo1_ff  <= reg_wdata & TLBM_LO_MASK;
        TLBM_A_MASK: mask_ff <= reg_wdata & TLBM_PM_MASK;
        TLBM_A_HI:   hi_ff   <= reg_wdata & TLBM_HI_MASK;
        default:     hi_ff   <= hi_ff;
      endcase
    end
  end

  // Entry writes copy the staging registers into one slot.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_ENT; i++) begin
        ent_hi_ff[i]   <= 32'h00000000;
        ent_mask_ff[i] <= 32'h00000000;
        ent_lo0_ff[i]  <= 30'h00000000;
        ent_lo1_ff[i]  <= 30'h00000000;
        ent_g_ff[i]    <= 1'b0;
      end
    end else if (do_write) begin
      ent_hi_ff[wr_idx]   <= hi_ff;
      ent_mask_ff[wr_idx] <= mask_ff;
      ent_lo0_ff[wr_idx]  <= lo0_ff[29:0];
      ent_lo1_ff[wr_idx]  <= lo1_ff[29:0];
      ent_g_ff[wr_idx]    <= lo0_ff[TLBM_G_BIT] & lo1_ff[TLBM_G_BIT];
    end
  end

  // Translation of the lookup port; odd page picked by the lowest vpn bit.
  logic [29:0] lk_lo;
  logic [31:0] pg_msk;
  logic        odd_sel;
  always_comb begin
    pg_msk  = ent_mask_ff[look_idx] | 32'h00000FFF;
    odd_sel = |(lk_vaddr & ((pg_msk >> 1) ^ pg_msk) & ~32'h00000FFF)
              | (lk_vaddr[12] & ~|ent_mask_ff[look_idx]);
    lk_lo   = odd_sel ? ent_lo1_ff[look_idx] : ent_lo0_ff[look_idx];
  end

  logic ev_miss;
  logic ev_inv;
  logic ev_mod;
  assign ev_miss = lk_valid && !(|look_hit);
  assign ev_inv  = lk_valid && (|look_hit) && !lk_lo[TLBM_V_BIT];
  assign ev_mod  = lk_valid && (|look_hit) && lk_lo[TLBM_V_BIT] &&
                   lk_store && !lk_lo[TLBM_D_BIT];

  // Lookup results registered one cycle after the request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_hit           <= 1'b0;
      lk_paddr         <= 32'h00000000;
      lk_uncached      <= 1'b0;
      lk_exc_miss      <= 1'b0;
      lk_exc_load_inv  <= 1'b0;
      lk_exc_store_inv <= 1'b0;
      lk_exc_mod       <= 1'b0;
    end else begin
      lk_hit           <= lk_valid && (|look_hit) && lk_lo[TLBM_V_BIT];
      lk_paddr         <= ({lk_lo[27:6], 10'h000} & ~pg_msk)
                          | (lk_vaddr & pg_msk);
      lk_uncached      <= (lk_lo[5:3] == TLBM_C_UNCACHED);
      lk_exc_miss      <= ev_miss;
      lk_exc_load_inv  <= ev_inv && !lk_store;
      lk_exc_store_inv <= ev_inv && lk_store;
      lk_exc_mod       <= ev_mod;
    end
  end

  // Sticky event status; a read clears, a new event in that cycle wins.
  logic [TLBM_EV_W-1:0] ev_vec;
  assign ev_vec = {ev_mod, ev_inv, ev_miss};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_ff <= TLBM_EV_NONE;
    end else if (reg_rd && reg_addr == TLBM_A_IRQ_ST) begin
      ist_ff <= ev_vec;
    end else begin
      ist_ff <= ist_ff | ev_vec;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      imsk_ff <= TLBM_EV_NONE;
    end else if (reg_wr && reg_addr == TLBM_A_IRQ_MSK) begin
      imsk_ff <= reg_wdata[TLBM_EV_W-1:0];
    end
  end

  assign irq = |(ist_ff & imsk_ff);

  // Read mux; unmapped and reserved bits read as zero.
  always_comb begin
    case (reg_addr)
      TLBM_A_SEL:     nxt_rdata = sel_ff;
      TLBM_A_RAND:    nxt_rdata = {27'h0000000, rand_ff};
      TLBM_A_LO0:     nxt_rdata = lo0_ff;
      TLBM_A_LO1:     nxt_rdata = lo1_ff;
      TLBM_A_MASK:    nxt_rdata = mask_ff;
      TLBM_A_WIRED:   nxt_rdata = {27'h0000000, wired_ff};
      TLBM_A_HI:      nxt_rdata = hi_ff;
      TLBM_A_IRQ_ST:  nxt_rdata = {29'h00000000, ist_ff};
      TLBM_A_IRQ_MSK: nxt_rdata = {29'h00000000, imsk_ff};
      default:        nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Checks.
  AST_RAND_RANGE: assert property (@(posedge clk) disable iff (rst)
    rand_ff >= wired_ff || $past(reg_wr) )
    else $error("replacement index below boundary");
  AST_RAND_WIRED: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == TLBM_A_WIRED |=> rand_ff == TLBM_IDX_TOP)
    else $error("boundary write did not reload index");
  AST_RAND_DEC: assert property (@(posedge clk) disable iff (rst)
    instr_retire && !reg_wr && rand_ff > wired_ff
    |=> rand_ff == $past(rand_ff) - 5'h01)
    else $error("replacement index did not decrement");
  AST_RAND_WRAP: assert property (@(posedge clk) disable iff (rst)
    instr_retire && !reg_wr && rand_ff <= wired_ff
    |=> rand_ff == TLBM_IDX_TOP)
    else $error("replacement index did not wrap");
  AST_PROBE_MISS: assert property (@(posedge clk) disable iff (rst)
    do_probe && !(|probe_hit) |=> sel_ff[TLBM_PROBE_BIT])
    else $error("probe miss flag not set");
  AST_PROBE_HIT: assert property (@(posedge clk) disable iff (rst)
    do_probe && (|probe_hit)
    |=> !sel_ff[TLBM_PROBE_BIT] && sel_ff[4:0] == $past(probe_idx))
    else $error("probe hit result wrong");
  AST_SEL_RSV: assert property (@(posedge clk) disable iff (rst)
    (sel_ff & ~TLBM_SEL_MASK) == 32'h00000000)
    else $error("selector reserved bits set");
  AST_INV_EXC: assert property (@(posedge clk) disable iff (rst)
    ev_inv && !lk_store |=> lk_exc_load_inv && !lk_hit)
    else $error("invalid load not flagged");
  AST_UNCACHED: assert property (@(posedge clk) disable iff (rst)
    lk_valid && lk_lo[5:3] == TLBM_C_UNCACHED |=> lk_uncached)
    else $error("uncached attribute missed");
  AST_RRD_WR: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == TLBM_A_RAND && !instr_retire
    |=> rand_ff == $past(rand_ff))
    else $error("replacement index was writable");

  // Software writes reach the selector and the boundary with masking.
  AST_SEL_WR: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == TLBM_A_SEL && !do_probe
    |=> sel_ff == ($past(reg_wdata) & TLBM_SEL_MASK))
    else $error("selector write lost");
  AST_WIRED_WR: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == TLBM_A_WIRED
    |=> wired_ff == $past(reg_wdata[4:0]))
    else $error("boundary write lost");

  // Entry moves use the right slot and the right staging values.
  AST_RD_IDX: assert property (@(posedge clk) disable iff (rst)
    do_read |=> mask_ff == $past(ent_mask_ff[sel_ff[4:0]]))
    else $error("indexed read used wrong entry");
  AST_WRRND_IDX: assert property (@(posedge clk) disable iff (rst)
    do_wrrnd |=> ent_hi_ff[$past(rand_ff)] == $past(hi_ff))
    else $error("random write used wrong entry");
  AST_WRIDX_IDX: assert property (@(posedge clk) disable iff (rst)
    do_wridx |=> ent_mask_ff[$past(sel_ff[4:0])] == $past(mask_ff))
    else $error("indexed write used wrong entry");
  AST_GLOBAL: assert property (@(posedge clk) disable iff (rst)
    do_write |=> ent_g_ff[$past(wr_idx)]
      == ($past(lo0_ff[TLBM_G_BIT]) & $past(lo1_ff[TLBM_G_BIT])))
    else $error("global bit not the AND of both halves");

  // Lookup faults are reported one cycle after the request.
  AST_MISS_EXC: assert property (@(posedge clk) disable iff (rst)
    lk_valid && !(|look_hit) |=> lk_exc_miss && !lk_hit)
    else $error("lookup miss not flagged");
  AST_STORE_INV: assert property (@(posedge clk) disable iff (rst)
    ev_inv && lk_store |=> lk_exc_store_inv && !lk_exc_load_inv)
    else $error("invalid store not flagged");
  AST_MOD_EXC: assert property (@(posedge clk) disable iff (rst)
    ev_mod |=> lk_exc_mod)
    else $error("write to protected page not flagged");

  // Read data stand only in the cycle after a read strobe.
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not cleared when idle");
endmodule

// ---- tb/tlbm_pipe_model.sv ----
// Purpose: Pipeline stand-in that issues TLB instructions and retires work.
// Assumes: One TLB instruction in flight at a time.
// Notes:   A per-request delay mimics both prompt and slow pipelines.
`timescale 1ns/100ps
module tlbm_pipe_model
  import tlbm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       issue,
  input  wire logic [2:0] issue_op,
  input  wire logic [3:0] issue_dly,
  input  wire logic       run,
  output logic      [2:0] op_code,
  output logic            op_valid,
  output logic            instr_retire,
  output logic            pend_ff
);
  logic [3:0] cnt_ff;
  logic [2:0] op_ff;
  // Holds a request for its delay, then pulses the instruction once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_ff  <= 1'b0;
      cnt_ff   <= 4'h0;
      op_ff    <= TLBM_OP_NONE;
      op_valid <= 1'b0;
      op_code  <= TLBM_OP_NONE;
    end else begin
      op_valid <= 1'b0;
      op_code  <= TLBM_OP_NONE;
      if (!pend_ff && issue) begin
        pend_ff <= 1'b1;
        cnt_ff  <= issue_dly;
        op_ff   <= issue_op;
      end else if (pend_ff && cnt_ff == 4'h0) begin
        pend_ff  <= 1'b0;
        op_valid <= 1'b1;
        op_code  <= op_ff;
      end else if (pend_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  // Every issued TLB instruction also counts as an executed one.
  assign instr_retire = run | op_valid;
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the TLB management block.
// Assumes: Lookups use the smallest page so the page mask stays zero.
// Notes:   A reference model updates on the falling edge from bus inputs.
`timescale 1ns/100ps
module testbench;
  import tlbm_pkg::*;
  logic        clk, rst, reg_wr, reg_rd, lk_valid, lk_store, issue, run;
  logic        op_valid, instr_retire, pend, lk_hit, lk_uncached, irq;
  logic        lk_exc_miss, lk_exc_load_inv, lk_exc_store_inv, lk_exc_mod;
  logic        run_en;
  logic [4:0]  reg_addr;
  logic [2:0]  op_code, issue_op;
  logic [3:0]  issue_dly;
  logic [31:0] reg_wdata, reg_rdata, lk_vaddr, lk_paddr;
  logic [31:0] m_sel, m_lo0, m_lo1, m_pm, m_hi, m_st, m_msk;
  logic [31:0] e_hi[32], e_pm[32], e_l0[32], e_l1[32];
  logic        e_g[32];
  int          m_rnd, m_bnd, mismatches, total_checks, cyc;
  logic [4:0]  regs[7] = '{TLBM_A_SEL, TLBM_A_LO0, TLBM_A_LO1, TLBM_A_MASK,
                           TLBM_A_HI, TLBM_A_RAND, TLBM_A_IRQ_MSK};

  tlbm_core DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .op_code, .op_valid, .instr_retire, .lk_valid, .lk_vaddr,
    .lk_store, .lk_hit, .lk_paddr, .lk_uncached, .lk_exc_miss,
    .lk_exc_load_inv, .lk_exc_store_inv, .lk_exc_mod, .irq);
  tlbm_pipe_model pipe (.clk, .rst, .issue, .issue_op, .issue_dly, .run,
    .op_code, .op_valid, .instr_retire, .pend_ff(pend));

  // Lowest entry whose page and space identifier match wins.
  function automatic int find(logic [31:0] va);
    find = -1;
    for (int i = 31; i >= 0; i--)
      if (e_hi[i][31:13] == va[31:13] &&
          (e_g[i] || e_hi[i][7:0] == m_hi[7:0]))
        find = i;
  endfunction
  // Event bits of one lookup: miss, invalid, modified.
  function automatic logic [2:0] lkev(logic [31:0] va, logic st);
    int f;
    logic [31:0] lo;
    f = find(va);
    if (f < 0) return 3'h1;
    lo = va[12] ? e_l1[f] : e_l0[f];
    if (!lo[TLBM_V_BIT]) return 3'h2;
    return (st && !lo[TLBM_D_BIT]) ? 3'h4 : 3'h0;
  endfunction
  function automatic logic [31:0] rd_exp(logic [4:0] a);
    case (a)
      TLBM_A_SEL:     return m_sel;
      TLBM_A_RAND:    return 32'(m_rnd);
      TLBM_A_LO0:     return m_lo0;
      TLBM_A_LO1:     return m_lo1;
      TLBM_A_MASK:    return m_pm;
      TLBM_A_WIRED:   return 32'(m_bnd);
      TLBM_A_HI:      return m_hi;
      TLBM_A_IRQ_ST:  return m_st;
      TLBM_A_IRQ_MSK: return m_msk;
      default:        return 32'h0;
    endcase
  endfunction

  // Reference model: applies what the next rising edge will take.
  always @(negedge clk) begin
    int i, f;
    if (rst) begin
      {m_sel, m_lo0, m_lo1, m_pm, m_hi, m_st, m_msk} = '0;
      m_rnd = 31;
      m_bnd = 0;
      for (int k = 0; k < 32; k++) begin
        {e_hi[k], e_pm[k], e_l0[k], e_l1[k], e_g[k]} = '0;
      end
    end else begin
      i = (op_code == TLBM_OP_WRRND) ? m_rnd : int'(m_sel[4:0]);
      if (reg_rd && reg_addr == TLBM_A_IRQ_ST) m_st = 32'h0;
      if (lk_valid) m_st |= 32'(lkev(lk_vaddr, lk_store));
      if (reg_wr) begin
        case (reg_addr)
          TLBM_A_SEL:     m_sel = reg_wdata & TLBM_SEL_MASK;
          TLBM_A_LO0:     m_lo0 = reg_wdata & TLBM_LO_MASK;
          TLBM_A_LO1:     m_lo1 = reg_wdata & TLBM_LO_MASK;
          TLBM_A_MASK:    m_pm = reg_wdata & TLBM_PM_MASK;
          TLBM_A_HI:      m_hi = reg_wdata & TLBM_HI_MASK;
          TLBM_A_IRQ_MSK: m_msk = reg_wdata & 32'h00000007;
          TLBM_A_WIRED: begin
            m_bnd = int'(reg_wdata[4:0]);
            m_rnd = 31;
          end
          default: ;
        endcase
      end
      if (instr_retire && !(reg_wr && reg_addr == TLBM_A_WIRED))
        m_rnd = (m_rnd <= m_bnd) ? 31 : m_rnd - 1;
      if (op_valid && op_code == TLBM_OP_PROBE) begin
        f = find(m_hi);
        if (f < 0) m_sel[TLBM_PROBE_BIT] = 1'b1;
        else m_sel = 32'(f);
      end else if (op_valid && op_code == TLBM_OP_READ) begin
        m_hi = e_hi[i];
        m_pm = e_pm[i];
        m_lo0 = {e_l0[i][31:1], e_g[i]};
        m_lo1 = {e_l1[i][31:1], e_g[i]};
      end else if (op_valid && op_code != TLBM_OP_NONE) begin
        {e_hi[i], e_pm[i], e_l0[i], e_l1[i]} = {m_hi, m_pm, m_lo0, m_lo1};
        e_g[i] = m_lo0[0] & m_lo1[0];
      end
    end
  end

  // Clock and pipeline activity; the activity is random.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) run <= run_en & 1'($urandom_range(1));
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Boundary writes keep the pipeline quiet so the reload is clean.
  task automatic wr(logic [4:0] a, logic [31:0] d);
    if (a == TLBM_A_WIRED) run_en = 1'b0;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    run_en = 1'b1;
  endtask
  task automatic rd(logic [4:0] a);
    logic [31:0] e;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    e = rd_exp(a);
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic op(logic [2:0] c);
    int n;
    @(posedge clk);
    issue <= 1'b1;
    issue_op <= c;
    issue_dly <= 4'($urandom_range(3));
    @(posedge clk);
    issue <= 1'b0;
    n = 0;
    #1;
    while (pend === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
  endtask
  task automatic look(logic [31:0] va, logic st);
    logic [2:0] ev;
    logic [31:0] lo;
    @(posedge clk);
    lk_valid <= 1'b1;
    lk_vaddr <= va;
    lk_store <= st;
    ev = lkev(va, st);
    lo = (ev == 3'h1) ? 32'h0 : (va[12] ? e_l1[find(va)] : e_l0[find(va)]);
    @(posedge clk);
    lk_valid <= 1'b0;
    #1;
    chk(32'({lk_exc_miss, lk_exc_load_inv, lk_exc_store_inv, lk_exc_mod}),
        32'({ev[0], ev[1] & !st, ev[1] & st, ev[2]}));
    chk(32'(irq), 32'(|(m_st & m_msk)));
    if (ev == 3'h0) begin
      chk(32'({lk_hit, lk_uncached}),
          32'({1'b1, lo[5:3] == TLBM_C_UNCACHED}));
      chk(lk_paddr, {lo[27:8], va[11:0]});
    end else if (ev[0]) chk(32'(lk_hit), 32'h0);
  endtask

  // Main sequence.
  initial begin
    {reg_wr, reg_rd, lk_valid, lk_store, issue, run, run_en} = '0;
    {reg_addr, reg_wdata, lk_vaddr, issue_op, issue_dly} = '0;
    mismatches = 0;
    total_checks = 0;
    cyc = 0;
    rst = 1'b1;
    void'($urandom(62023));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    run_en = 1'b1;
    for (int a = 0; a < 32; a++) rd(5'(a));
    foreach (regs[j]) begin
      wr(regs[j], $urandom & 32'h7FFFFFFF);
      rd(regs[j]);
    end
    wr(TLBM_A_MASK, 32'h0);
    for (int k = 0; k < 32; k++) begin
      wr(TLBM_A_HI, {19'(k % 12), 5'h0, 8'($urandom_range(1))});
      wr(TLBM_A_LO0, $urandom & TLBM_LO_MASK);
      wr(TLBM_A_LO1, $urandom & TLBM_LO_MASK);
      wr(TLBM_A_SEL, 32'(k));
      op(k < 24 ? TLBM_OP_WRIDX : TLBM_OP_WRRND);
    end
    for (int k = 0; k < 32; k++) begin
      wr(TLBM_A_SEL, 32'(k));
      op(TLBM_OP_READ);
      for (int j = 0; j < 5; j++) rd(regs[j]);
    end
    foreach (regs[j]) if (j < 3) begin
      wr(TLBM_A_WIRED, 32'(5'(28 + 3 * j - 12 * j * j)));
      rd(TLBM_A_WIRED);
      repeat (10) rd(TLBM_A_RAND);
      repeat (3) op(TLBM_OP_WRRND);
    end
    for (int v = 8; v < 14; v++) begin
      wr(TLBM_A_HI, {19'(v), 13'h0});
      op(TLBM_OP_PROBE);
      rd(TLBM_A_SEL);
    end
    for (int r = 0; r < 2; r++) begin
      wr(TLBM_A_HI, 32'(r));
      wr(TLBM_A_IRQ_MSK, r ? 32'h7 : 32'h5);
      repeat (24) look({19'($urandom_range(13)), 13'($urandom)},
                       1'($urandom_range(1)));
      rd(TLBM_A_IRQ_ST);
      rd(TLBM_A_IRQ_ST);
    end
    wrap_up();
  end
endmodule
